// [core/wsrwd_regs.svh]
`ifndef WSRWD_REGS_SVH
`define WSRWD_REGS_SVH

// Clock rate and printed times
`define WSRWD_CLK_MHZ        20
`define WSRWD_T_INIT_US      381
`define WSRWD_T_SETTLE_US    150
`define WSRWD_T_RST_NC_MS    200
`define WSRWD_T_RST_PU_MS    10
`define WSRWD_T_CAP_MIN_US   703
`define WSRWD_T_CAP_MAX_MS   3220
`define WSRWD_US_PER_MS      1000

// Watchdog window bounds, unconnected timing pin, in microseconds
`define WSRWD_WDL_R18_US     22500
`define WSRWD_WDL_R34_US     1850
`define WSRWD_WDL_R12_US     800000
`define WSRWD_WDU_R18_US     55000
`define WSRWD_WDU_R34_US     27500
`define WSRWD_WDU_R12_US     1600000

// Mode pin codes {pin_a, pin_b}
`define WSRWD_MODE_R18       2'h0
`define WSRWD_MODE_R34       2'h1
`define WSRWD_MODE_OFF       2'h2
`define WSRWD_MODE_R12       2'h3

// Register byte offsets
`define WSRWD_OFF_CTRL       8'h00
`define WSRWD_OFF_CAPDLY     8'h04
`define WSRWD_OFF_STATUS     8'h08

// Field positions
`define WSRWD_CTRL_ADJ       0
`define WSRWD_STS_RST        0
`define WSRWD_STS_FAULT      1
`define WSRWD_STS_CLS_LSB    2
`define WSRWD_STS_CLS_MSB    3
`define WSRWD_STS_WDEN       4
`define WSRWD_STS_RAT_LSB    5
`define WSRWD_STS_RAT_MSB    6
`define WSRWD_STS_RSTPIN     7
`define WSRWD_STS_WDOPIN     8

// Synchroniser lanes
`define WSRWD_SYN_UV         0
`define WSRWD_SYN_OV         1
`define WSRWD_SYN_SUP        2
`define WSRWD_SYN_MA         3
`define WSRWD_SYN_MB         4
`define WSRWD_SYN_KICK       5
`define WSRWD_SYN_DHI        6
`define WSRWD_SYN_DCAP       7
`define WSRWD_SYN_RSTPIN     8
`define WSRWD_SYN_WDOPIN     9
`define WSRWD_SYN_W          10

`endif

// [core/wsrwd_pkg.sv]
package wsrwd_pkg;
  typedef enum logic [3:0] {
    SUP_RST   = 4'h1,
    SUP_EVAL  = 4'h2,
    SUP_DELAY = 4'h4,
    SUP_RUN   = 4'h8
  } wsrwd_sup_t;

  typedef enum logic [4:0] {
    WD_OFF    = 5'h01,
    WD_SETTLE = 5'h02,
    WD_WAIT   = 5'h04,
    WD_WATCH  = 5'h08,
    WD_FAULT  = 5'h10
  } wsrwd_wd_t;

  typedef enum logic [1:0] {
    CLS_NC  = 2'h0,
    CLS_PU  = 2'h1,
    CLS_CAP = 2'h2
  } wsrwd_cls_t;
endpackage : wsrwd_pkg

// [core/wsrwd_wd_if.sv]
`timescale 1ns/100ps
// Supervisor to window watchdog link
interface wsrwd_wd_if;
  logic        released;
  logic        enabled;
  logic        cap_mode;
  logic        kick_fall;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [31:0] rst_cyc;
  logic        fault;
  modport sup (output released, enabled, cap_mode, kick_fall, lo, hi, rst_cyc, input fault);
  modport wdt (input released, enabled, cap_mode, kick_fall, lo, hi, rst_cyc, output fault);
endinterface : wsrwd_wd_if

// [core/wsrwd_wdt.sv]
`timescale 1ns/100ps
`include "wsrwd_regs.svh"

module wsrwd_wdt (
  input  wire logic   i_sys_clk,
  input  wire logic   i_rstn,
  wsrwd_wd_if.wdt     wd
);
  localparam logic [31:0] SETTLE_CYC = 32'(`WSRWD_T_SETTLE_US * `WSRWD_CLK_MHZ);

  wsrwd_pkg::wsrwd_wd_t st, next_st;
  logic [31:0]          cnt;
  logic                 first;
  logic                 pend;
  logic                 good_kick;

  ////////////////////////////////////////////////////////////////////////////
  // Kick judged against the window; first kick only has an upper bound
  assign good_kick = wd.kick_fall && (cnt < wd.hi) && (first || cnt >= wd.lo);

  // Next state; reset or disable parks everything
  always_comb begin
    next_st = st;
    if (!wd.released) begin
      next_st = wsrwd_pkg::WD_OFF;
    end else if (!wd.enabled && st != wsrwd_pkg::WD_OFF) begin
      next_st = wsrwd_pkg::WD_OFF;
    end else begin
      case (st)
        wsrwd_pkg::WD_OFF: begin
          if (wd.enabled) begin
            next_st = pend ? wsrwd_pkg::WD_WAIT : wsrwd_pkg::WD_SETTLE;
          end
        end
        wsrwd_pkg::WD_SETTLE: begin
          if (cnt == SETTLE_CYC - 32'h1) next_st = wsrwd_pkg::WD_WATCH;
        end
        wsrwd_pkg::WD_WAIT: begin
          if (cnt == wd.rst_cyc - 32'h1) next_st = wsrwd_pkg::WD_WATCH;
        end
        wsrwd_pkg::WD_WATCH: begin
          if (!good_kick && (wd.kick_fall || cnt == wd.hi - 32'h1)) next_st = wsrwd_pkg::WD_FAULT;
        end
        wsrwd_pkg::WD_FAULT: begin
          if (cnt == wd.rst_cyc - 32'h1) next_st = wsrwd_pkg::WD_WATCH;
        end
        default: next_st = wsrwd_pkg::WD_OFF;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) st <= wsrwd_pkg::WD_OFF;
    else         st <= next_st;
  end

  // Timer restarts on every state change and on every good kick while watching
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn)                                     cnt <= 32'h0;
    else if (next_st != st || (st == wsrwd_pkg::WD_WATCH && good_kick)) cnt <= 32'h0;
    else                                             cnt <= 32'(cnt + 32'h1);
  end

  // First kick after any (re)start of watching is exempt from the lower bound
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn)                      first <= 1'b1;
    else if (st != wsrwd_pkg::WD_WATCH) first <= 1'b1;
    else if (good_kick)               first <= 1'b0;
  end

  // Fault drive follows the fault state
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) wd.fault <= 1'b0;
    else         wd.fault <= (next_st == wsrwd_pkg::WD_FAULT);
  end

  // Capacitor timing: a fault cut short by disable owes a full delay later
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend <= 1'b0;
    end else if (st == wsrwd_pkg::WD_FAULT && !wd.enabled && wd.cap_mode && wd.released) begin
      pend <= 1'b1;
    end else if (!wd.released || (st == wsrwd_pkg::WD_WAIT && next_st == wsrwd_pkg::WD_WATCH)) begin
      pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  a_reset_quiet: assert property (!wd.released |=> !wd.fault)
    else $error("fault driven during system reset");
  a_off_quiet: assert property (!wd.enabled |=> !wd.fault)
    else $error("fault driven while watchdog disabled");
  a_settle_len: assert property ((st == wsrwd_pkg::WD_SETTLE && next_st == wsrwd_pkg::WD_WATCH)
    |-> cnt == SETTLE_CYC - 32'h1)
    else $error("settle period wrong length");
  a_settle_deaf: assert property ((st == wsrwd_pkg::WD_SETTLE && wd.enabled && wd.released
    && wd.kick_fall && cnt < SETTLE_CYC - 32'h1) |=> st == wsrwd_pkg::WD_SETTLE && !wd.fault)
    else $error("kick acted during settle");
  a_first_free: assert property ((st == wsrwd_pkg::WD_WATCH && first && wd.kick_fall && cnt < wd.hi
    && wd.enabled && wd.released) |=> st == wsrwd_pkg::WD_WATCH && !wd.fault)
    else $error("first kick treated as fault");
  a_early_fault: assert property ((st == wsrwd_pkg::WD_WATCH && !first && wd.kick_fall && cnt < wd.lo
    && wd.enabled && wd.released) |=> wd.fault)
    else $error("early kick not flagged");
  a_cap_wait: assert property ((st == wsrwd_pkg::WD_OFF && pend && wd.enabled && wd.released)
    |=> st == wsrwd_pkg::WD_WAIT ##1 !wd.fault)
    else $error("re-enable skipped delay wait");

  c_fault: cover property (st == wsrwd_pkg::WD_WATCH ##1 st == wsrwd_pkg::WD_FAULT);
  c_cap_wait: cover property (st == wsrwd_pkg::WD_WAIT ##1 st == wsrwd_pkg::WD_WATCH);
endmodule : wsrwd_wdt

// [core/wsrwd_top.sv]
`timescale 1ns/100ps
`include "wsrwd_regs.svh"

// Overview of operation
// - On each re-entry into the valid window, evaluate delay select pin for 381 us.
// - Evaluation classifies delay pin: unconnected, pulled up, or capacitor.
// - Classification picks the reset delay length.
// - Rail inside window with supply good keeps reset released.
// - Rail below undervoltage or above overvoltage drives reset low.
// - After re-entry, reset stays low a full delay, then releases.
// - Capacitor delay spans 703 us to 3.22 s.
// - Adjustable variant ignores overvoltage, monitors undervoltage only.
// - Enable or disable through mode pins acts at once.
// - Ratio change between enabled codes waits for a reset event to latch.
// - After disabled-to-enabled, kicks are ignored for 150 us.
// - Fixed timing: disable and re-enable during fault acts like plain enable.
// - Capacitor timing: disable releases fault; re-enable waits full reset delay.
// - Four modes: disabled, ratio 1:8, 3:4 or 1:2.
// - Pin a high with pin b low means watchdog disabled.
// - Disabled watchdog never drives its fault output.
// - Latching reset events: overvoltage, undervoltage or supply lockout.
// - Codes: both low 1/8, a low b high 3/4, both high 1/2.
// - Falling kicks must land inside the window, else fault low for one delay.
// - During system reset the watchdog is off and its fault output released.
// - First kick after start has only the upper bound.
module wsrwd_top #(
  parameter logic [31:0] INIT_CYC    = 32'(`WSRWD_T_INIT_US * `WSRWD_CLK_MHZ),
  parameter logic [31:0] RST_NC_CYC  = 32'(`WSRWD_T_RST_NC_MS * `WSRWD_US_PER_MS * `WSRWD_CLK_MHZ),
  parameter logic [31:0] RST_PU_CYC  = 32'(`WSRWD_T_RST_PU_MS * `WSRWD_US_PER_MS * `WSRWD_CLK_MHZ),
  parameter logic [31:0] CAP_MIN_CYC = 32'(`WSRWD_T_CAP_MIN_US * `WSRWD_CLK_MHZ),
  parameter logic [31:0] CAP_MAX_CYC = 32'(`WSRWD_T_CAP_MAX_MS * `WSRWD_US_PER_MS * `WSRWD_CLK_MHZ),
  parameter logic [31:0] WDL_R18_CYC = 32'(`WSRWD_WDL_R18_US * `WSRWD_CLK_MHZ),
  parameter logic [31:0] WDL_R34_CYC = 32'(`WSRWD_WDL_R34_US * `WSRWD_CLK_MHZ),
  parameter logic [31:0] WDL_R12_CYC = 32'(`WSRWD_WDL_R12_US * `WSRWD_CLK_MHZ),
  parameter logic [31:0] WDU_R18_CYC = 32'(`WSRWD_WDU_R18_US * `WSRWD_CLK_MHZ),
  parameter logic [31:0] WDU_R34_CYC = 32'(`WSRWD_WDU_R34_US * `WSRWD_CLK_MHZ),
  parameter logic [31:0] WDU_R12_CYC = 32'(`WSRWD_WDU_R12_US * `WSRWD_CLK_MHZ)
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_rail_above_uv,
  input  wire logic        i_rail_above_ov,
  input  wire logic        i_supply_above_lockout,
  input  wire logic        i_wd_mode_pin_a,
  input  wire logic        i_wd_mode_pin_b,
  input  wire logic        i_wd_kick_input,
  input  wire logic        i_reset_delay_select_pin_high,
  input  wire logic        i_reset_delay_select_pin_cap,
  input  wire logic        i_sys_reset_pin_in,
  output logic             o_sys_reset_pin_out,
  output logic             o_sys_reset_pin_oe,
  input  wire logic        i_wd_fault_output_in,
  output logic             o_wd_fault_output_out,
  output logic             o_wd_fault_output_oe
);
  logic [`WSRWD_SYN_W-1:0] raw, syn_a, syn_b, syn_c, stab;
  wsrwd_pkg::wsrwd_sup_t   st, next_st;
  wsrwd_pkg::wsrwd_cls_t   dly_class;
  logic [31:0]             cnt;
  logic [31:0]             rst_target;
  logic [31:0]             cap_dly;
  logic [1:0]              mode_pins;
  logic [1:0]              ratio_lat;
  logic                    ctrl_adj;
  logic                    win_ok;
  logic                    kick_prev;
  logic                    apb_setup, apb_done, apb_hit;
  logic [31:0]             rd_mux;
  wsrwd_wd_if              wd_kick_input ();

  ////////////////////////////////////////////////////////////////////////////
  // Raw asynchronous inputs gathered into lanes
  assign raw[`WSRWD_SYN_UV]     = i_rail_above_uv;
  assign raw[`WSRWD_SYN_OV]     = i_rail_above_ov;
  assign raw[`WSRWD_SYN_SUP]    = i_supply_above_lockout;
  assign raw[`WSRWD_SYN_MA]     = i_wd_mode_pin_a;
  assign raw[`WSRWD_SYN_MB]     = i_wd_mode_pin_b;
  assign raw[`WSRWD_SYN_KICK]   = i_wd_kick_input;
  assign raw[`WSRWD_SYN_DHI]    = i_reset_delay_select_pin_high;
  assign raw[`WSRWD_SYN_DCAP]   = i_reset_delay_select_pin_cap;
  assign raw[`WSRWD_SYN_RSTPIN] = i_sys_reset_pin_in;
  assign raw[`WSRWD_SYN_WDOPIN] = i_wd_fault_output_in;

  // Three-stage sync; value taken only when stages two and three agree
  for (genvar g = 0; g < `WSRWD_SYN_W; g++) begin : g_sync
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        syn_a[g] <= 1'b0;
        syn_b[g] <= 1'b0;
        syn_c[g] <= 1'b0;
        stab[g]  <= 1'b0;
      end else begin
        syn_a[g] <= raw[g];
        syn_b[g] <= syn_a[g];
        syn_c[g] <= syn_b[g];
        if (syn_b[g] == syn_c[g]) stab[g] <= syn_c[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window check; adjustable variant drops the overvoltage side
  assign win_ok = stab[`WSRWD_SYN_SUP] && stab[`WSRWD_SYN_UV]
                  && (ctrl_adj || !stab[`WSRWD_SYN_OV]);

  // Delay length by classification; capacitor value clamped to its range
  always_comb begin
    case (dly_class)
      wsrwd_pkg::CLS_PU:  rst_target = RST_PU_CYC;
      wsrwd_pkg::CLS_CAP: rst_target = (cap_dly < CAP_MIN_CYC) ? CAP_MIN_CYC :
                                       (cap_dly > CAP_MAX_CYC) ? CAP_MAX_CYC : cap_dly;
      default:            rst_target = RST_NC_CYC;
    endcase
  end

  // Supervisor sequence: any loss of window goes straight back to reset
  always_comb begin
    next_st = st;
    case (st)
      wsrwd_pkg::SUP_RST: begin
        if (win_ok) next_st = wsrwd_pkg::SUP_EVAL;
      end
      wsrwd_pkg::SUP_EVAL: begin
        if (!win_ok)                        next_st = wsrwd_pkg::SUP_RST;
        else if (cnt == INIT_CYC - 32'h1)   next_st = wsrwd_pkg::SUP_DELAY;
      end
      wsrwd_pkg::SUP_DELAY: begin
        if (!win_ok)                        next_st = wsrwd_pkg::SUP_RST;
        else if (cnt == rst_target - 32'h1) next_st = wsrwd_pkg::SUP_RUN;
      end
      wsrwd_pkg::SUP_RUN: begin
        if (!win_ok) next_st = wsrwd_pkg::SUP_RST;
      end
      default: next_st = wsrwd_pkg::SUP_RST;
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) st <= wsrwd_pkg::SUP_RST;
    else         st <= next_st;
  end

  // Phase timer, cleared on every state change so each delay runs in full
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn)              cnt <= 32'h0;
    else if (next_st != st)   cnt <= 32'h0;
    else                      cnt <= 32'(cnt + 32'h1);
  end

  // Classification taken when evaluation completes; capacitor wins over pull-up
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dly_class <= wsrwd_pkg::CLS_NC;
    end else if (st == wsrwd_pkg::SUP_EVAL && next_st == wsrwd_pkg::SUP_DELAY) begin
      if (stab[`WSRWD_SYN_DCAP])     dly_class <= wsrwd_pkg::CLS_CAP;
      else if (stab[`WSRWD_SYN_DHI]) dly_class <= wsrwd_pkg::CLS_PU;
      else                           dly_class <= wsrwd_pkg::CLS_NC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode pins: enable acts live, ratio is latched only while in reset
  assign mode_pins = {stab[`WSRWD_SYN_MA], stab[`WSRWD_SYN_MB]};

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ratio_lat <= `WSRWD_MODE_R18;
    end else if (st == wsrwd_pkg::SUP_RST && mode_pins != `WSRWD_MODE_OFF) begin
      ratio_lat <= mode_pins;
    end
  end

  // Falling kick edge from the settled value only
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) kick_prev <= 1'b0;
    else         kick_prev <= stab[`WSRWD_SYN_KICK];
  end

  // Window bounds for the latched ratio
  always_comb begin
    case (ratio_lat)
      `WSRWD_MODE_R34: begin wd_kick_input.lo = WDL_R34_CYC; wd_kick_input.hi = WDU_R34_CYC; end
      `WSRWD_MODE_R12: begin wd_kick_input.lo = WDL_R12_CYC; wd_kick_input.hi = WDU_R12_CYC; end
      default:         begin wd_kick_input.lo = WDL_R18_CYC; wd_kick_input.hi = WDU_R18_CYC; end
    endcase
  end

  assign wd_kick_input.released  = (st == wsrwd_pkg::SUP_RUN);
  assign wd_kick_input.enabled   = (mode_pins != `WSRWD_MODE_OFF);
  assign wd_kick_input.cap_mode  = (dly_class == wsrwd_pkg::CLS_CAP);
  assign wd_kick_input.kick_fall = kick_prev && !stab[`WSRWD_SYN_KICK];
  assign wd_kick_input.rst_cyc   = rst_target;

  wsrwd_wdt u_wdt (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .wd        (wd_kick_input.wdt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain pins: enable high means pulling low
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sys_reset_pin_out   <= 1'b0;
      o_sys_reset_pin_oe    <= 1'b1;
      o_wd_fault_output_out <= 1'b0;
      o_wd_fault_output_oe  <= 1'b0;
    end else begin
      o_sys_reset_pin_out   <= 1'b0;
      o_sys_reset_pin_oe    <= (next_st != wsrwd_pkg::SUP_RUN);
      o_wd_fault_output_out <= 1'b0;
      o_wd_fault_output_oe  <= wd_kick_input.fault && (next_st == wsrwd_pkg::SUP_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB: one wait state so read data comes from a register
  assign apb_setup = i_psel && i_penable && !o_pready;
  assign apb_done  = i_psel && i_penable && o_pready;
  assign apb_hit   = (i_paddr == `WSRWD_OFF_CTRL) || (i_paddr == `WSRWD_OFF_CAPDLY)
                     || (i_paddr == `WSRWD_OFF_STATUS);

  always_comb begin
    rd_mux = 32'h0;
    case (i_paddr)
      `WSRWD_OFF_CTRL:   rd_mux[`WSRWD_CTRL_ADJ] = ctrl_adj;
      `WSRWD_OFF_CAPDLY: rd_mux = cap_dly;
      `WSRWD_OFF_STATUS: begin
        rd_mux[`WSRWD_STS_RST]                        = o_sys_reset_pin_oe;
        rd_mux[`WSRWD_STS_FAULT]                      = o_wd_fault_output_oe;
        rd_mux[`WSRWD_STS_CLS_MSB:`WSRWD_STS_CLS_LSB] = dly_class;
        rd_mux[`WSRWD_STS_WDEN]                       = wd_kick_input.enabled;
        rd_mux[`WSRWD_STS_RAT_MSB:`WSRWD_STS_RAT_LSB] = ratio_lat;
        rd_mux[`WSRWD_STS_RSTPIN]                     = stab[`WSRWD_SYN_RSTPIN];
        rd_mux[`WSRWD_STS_WDOPIN]                     = stab[`WSRWD_SYN_WDOPIN];
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= apb_setup;
      o_pslverr <= apb_setup && !apb_hit;
      o_prdata  <= (apb_setup && !i_pwrite) ? rd_mux : 32'h0;
    end
  end

  // Writable registers; writes land on the completing edge
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_adj <= 1'b0;
      cap_dly  <= CAP_MIN_CYC;
    end else if (apb_done && i_pwrite) begin
      if (i_paddr == `WSRWD_OFF_CTRL)   ctrl_adj <= i_pwdata[`WSRWD_CTRL_ADJ];
      if (i_paddr == `WSRWD_OFF_CAPDLY) cap_dly  <= i_pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  a_rst_on_loss: assert property ((st == wsrwd_pkg::SUP_RUN && !win_ok) |=> o_sys_reset_pin_oe)
    else $error("reset not driven on window loss");
  a_rst_release: assert property ((st == wsrwd_pkg::SUP_RUN && win_ok) |=> !o_sys_reset_pin_oe)
    else $error("reset driven with rail valid");
  a_eval_len: assert property ((st == wsrwd_pkg::SUP_EVAL && next_st == wsrwd_pkg::SUP_DELAY)
    |-> cnt == INIT_CYC - 32'h1)
    else $error("evaluation period wrong length");
  a_delay_len: assert property ((st == wsrwd_pkg::SUP_DELAY && next_st == wsrwd_pkg::SUP_RUN)
    |-> cnt == rst_target - 32'h1 ##1 !o_sys_reset_pin_oe)
    else $error("reset delay wrong length");
  a_class_pick: assert property ((dly_class == wsrwd_pkg::CLS_PU) |-> rst_target == RST_PU_CYC)
    else $error("pull-up delay not selected");
  a_cap_range: assert property ((dly_class == wsrwd_pkg::CLS_CAP)
    |-> rst_target >= CAP_MIN_CYC && rst_target <= CAP_MAX_CYC)
    else $error("capacitor delay out of range");
  a_adj_no_ov: assert property ((ctrl_adj && stab[`WSRWD_SYN_OV] && stab[`WSRWD_SYN_UV]
    && stab[`WSRWD_SYN_SUP]) |-> win_ok)
    else $error("overvoltage acted in adjustable variant");
  a_ratio_hold: assert property ((st != wsrwd_pkg::SUP_RST ##1 st != wsrwd_pkg::SUP_RST)
    |-> $stable(ratio_lat))
    else $error("ratio changed without reset event");
  a_delay_restart: assert property ((st == wsrwd_pkg::SUP_DELAY && !win_ok)
    |=> st == wsrwd_pkg::SUP_RST && o_sys_reset_pin_oe)
    else $error("delay not restarted on window loss");
  // Two-cycle lag: watchdog fault flop first, then the pin flop
  a_off_code: assert property ((mode_pins == `WSRWD_MODE_OFF) |=> ##1 !o_wd_fault_output_oe)
    else $error("fault output with watchdog disabled");

  c_release: cover property (st == wsrwd_pkg::SUP_DELAY ##1 st == wsrwd_pkg::SUP_RUN);
  c_cap_class: cover property (dly_class == wsrwd_pkg::CLS_CAP && st == wsrwd_pkg::SUP_RUN);
  c_wdo_low: cover property ($rose(o_wd_fault_output_oe));
endmodule : wsrwd_top

// [testbench/wsrwd_host_model.sv]
`timescale 1ns/100ps
// Supervised processor: strobes the kick line at a fixed period
module wsrwd_host_model #(
  parameter int PERIOD = 40
) (
  input  wire logic i_sys_clk,
  input  wire logic i_run,
  output logic      o_kick
);
  int cnt = 0;
  initial o_kick = 1'b0;
  // Falling edge once a period; stopping holds the level so no stray edge appears
  always @(posedge i_sys_clk) begin
    if (i_run) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_kick <= (cnt < PERIOD / 2);
    end
  end
endmodule : wsrwd_host_model

// [testbench/wsrwd_top_tb.sv]
`timescale 1ns/100ps
module wsrwd_top_tb;
  typedef struct {logic hi; logic cap; int dly; logic [1:0] cls;} wsrwd_row_t;
  logic        clk, rstn, psel, pen, pwr, uv, ov, sup, ma, mb, dhi, dcap, run;
  logic        kick, pready, perr, rst_out, rst_oe, wdo_out, wdo_oe, err_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          errors, cmp_count, cyc, n;
  wsrwd_row_t  rows [3] = '{'{0, 0, 40, 2'h0}, '{1, 0, 30, 2'h1}, '{1, 1, 14060, 2'h2}};

  // Short counts keep the run brief; capacitor bounds stay real (703 us is 14060 cycles)
  wsrwd_top #(.INIT_CYC(32'h14), .RST_NC_CYC(32'h28), .RST_PU_CYC(32'h1e),
    .WDL_R18_CYC(32'h14), .WDU_R18_CYC(32'h3c)) u_dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_rail_above_uv(uv),
    .i_rail_above_ov(ov), .i_supply_above_lockout(sup), .i_wd_mode_pin_a(ma), .i_wd_mode_pin_b(mb),
    .i_wd_kick_input(kick), .i_reset_delay_select_pin_high(dhi), .i_reset_delay_select_pin_cap(dcap),
    .i_sys_reset_pin_in(!rst_oe), .i_wd_fault_output_in(!wdo_oe), .o_sys_reset_pin_out(rst_out),
    .o_sys_reset_pin_oe(rst_oe), .o_wd_fault_output_out(wdo_out), .o_wd_fault_output_oe(wdo_oe));
  wsrwd_host_model u_host (.i_sys_clk(clk), .i_run(run), .o_kick(kick));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is seen at a rising edge; one idle edge follows
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err_q = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Rail out of window, back in; cycles from re-entry until release
  task automatic rail();
    uv <= 1'b0;
    repeat (10) @(posedge clk);
    chk(32'(rst_oe), 1);
    uv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rst_oe !== 1'b0 && n < 20000);
  endtask : rail

  task automatic wait_fault(input int lim);
    n = 0;
    while (wdo_oe !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_fault

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end

  // Hang guard, well above the expected length of the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    {rstn, psel, pen, pwr, ov, mb, dhi, dcap, run, paddr, pwdata} = '0;
    {uv, sup, ma} = 3'h7;
    repeat (8) @(posedge clk);
    chk({rst_oe, wdo_oe}, 2'h2);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      dhi <= rows[i].hi;
      dcap <= rows[i].cap;
      rail();
      chk(32'(n >= rows[i].dly + 20 && n <= rows[i].dly + 28), 1);
      apb(1'b0, 8'h08, 32'h0);
      chk(q[3:2], rows[i].cls);
    end
    apb(1'b1, 8'h04, 32'h64);
    rail();
    chk(32'(n >= 14080 && n <= 14088), 1);
    apb(1'b1, 8'h04, 32'h1000);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h1000);
    {dhi, dcap} <= 2'h0;
    uv <= 1'b0;
    repeat (10) @(posedge clk);
    uv <= 1'b1;
    repeat (40) @(posedge clk);
    rail();
    chk(32'(n >= 60 && n <= 68), 1);
    ov <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(rst_oe), 1);
    apb(1'b1, 8'h00, 32'h1);
    repeat (80) @(posedge clk);
    chk(32'(rst_oe), 0);
    ov <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0);
    chk(q, 32'h0);
    chk(32'(err_q), 1);
    chk(32'(wdo_oe), 0);
    run <= 1'b1;
    ma <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b0, 8'h08, 32'h0);
    chk(q[6:4], 3'h1);
    repeat (3400) @(posedge clk);
    chk(32'(wdo_oe), 0);
    run <= 1'b0;
    wait_fault(120);
    chk(32'(wdo_oe), 1);
    ma <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(wdo_oe), 0);
    ma <= 1'b0;
    repeat (2900) @(posedge clk);
    chk(32'(wdo_oe), 0);
    wait_fault(300);
    chk(32'(wdo_oe), 1);
    // Second pin only after 500 us (10000 cycles) since the last change of the first
    repeat (7200) @(posedge clk);
    mb <= 1'b1;
    repeat (10) @(posedge clk);
    apb(1'b0, 8'h08, 32'h0);
    chk(q[6:4], 3'h1);
    sup <= 1'b0;
    repeat (10) @(posedge clk);
    chk(32'(rst_oe), 1);
    apb(1'b0, 8'h08, 32'h0);
    chk(q[8:0], 9'h131);
    chk({rst_out, wdo_out}, 2'h0);
    give_verdict();
  end
endmodule : wsrwd_top_tb
